// File: pkg/qct_params.svh
/*
  Constants for the quick channel trigger and completion block: register offsets,
  setting-word field positions and reset values.
  Assumes byte addresses on a 16-bit register port with 32-bit data.
*/
// Function
// - software write to a mapped trigger word of an enabled channel sets its flag
// - a link update from a non-null link onto a mapped set of an enabled channel sets its flag
// - set flags are prioritised, queued, and evaluated at the queue head
// - a non-dummy set submits one transfer request; the channel may then retrigger
// - a trigger while the flag is still set and not being cleared sets the miss flag
// - with link hold clear, a link copy writing the trigger word is a new event
// - A-sync gives second times third requests of first-count bytes
// - AB-sync gives third-count requests of first times second bytes
// - the last request gives final codes and starts the link update
// - the 6-bit completion code picks one of 64 chain or pending bits
// - final enables act on the last request, midway enables on all others
// - every set carries a link address; FFFF means the null link
// - early finish 0: complete only when the transfer controller returns the code
// - early finish 1: complete at submission, code generated internally
// - dummy or null sets submit nothing but still raise enabled codes internally
// - an event on a null set raises an error that software clears
// - the code of any channel's set can pick any of the 64 chain and pending bits
// - a completion interface returns which transfer finished
// - eight quick channels, each with a bit in every region access register
// - after reset every map points at set 0, word 0; a map can pick any of the 8 words to trigger
`ifndef QCT_PARAMS_SVH
`define QCT_PARAMS_SVH

// register map, byte addresses; everything below MEM_TOP is setting memory
`define QCT_MEM_TOP    16'h1000
`define QCT_REG_FLAGS  16'h1000
`define QCT_REG_MISS   16'h1004
`define QCT_REG_EN     16'h1008
`define QCT_REG_CER_LO 16'h1010
`define QCT_REG_CER_HI 16'h1014
`define QCT_REG_IPR_LO 16'h1018
`define QCT_REG_IPR_HI 16'h101C
`define QCT_REG_RAE    16'h1020
`define QCT_REG_MAP    16'h1040

// set control word (word 0) fields
`define QCT_F_AB       0
`define QCT_F_HOLD     3
`define QCT_F_EARLY    11
`define QCT_F_CODE     12
`define QCT_F_FIRQ     20
`define QCT_F_MIRQ     21
`define QCT_F_FCH      22
`define QCT_F_MCH      23

// map register fields
`define QCT_MAP_SET    5
`define QCT_MAP_WORD   2

`define QCT_NULL_LINK  16'hFFFF
`define QCT_MAP_RST    10'h000

`endif

// File: pkg/qct_pkg.sv
/*
  Types for the quick channel trigger and completion block.
  Assumes the constants header is included by the design file.
*/
package qct_pkg;

  typedef logic [6:0] qct_set_t;
  typedef logic [2:0] qct_chan_t;

  typedef struct packed {
    qct_set_t   set;
    logic [2:0] word;
  } qct_map_t;

  typedef enum logic [2:0] {ST_IDLE, ST_EVAL, ST_SUBMIT, ST_WB, ST_LINK} qct_st_t;

  // request towards the transfer controller
  typedef struct packed {
    logic        valid;
    qct_chan_t   chan;
    qct_set_t    set;
    logic [31:0] bytes;
    logic [31:0] src;
    logic [31:0] dst;
    logic [5:0]  code;
    logic        ret_chain;
    logic        ret_irq;
    logic        final_tr;
  } qct_tr_t;

  // completion code returned by the transfer controller
  typedef struct packed {
    logic       valid;
    logic [5:0] code;
    logic       chain;
    logic       irq;
  } qct_done_t;

  typedef struct packed {
    logic [7:0]            flags;
    logic [7:0]            miss;
    logic [7:0]            en;
    logic [3:0][7:0]       rae;
    qct_map_t [7:0]        map;
    qct_chan_t [7:0]       queue;
    logic [2:0]            head;
    logic [2:0]            tail;
    logic [3:0]            cnt;
    logic [7:0]            queued;
    qct_st_t               st;
    qct_chan_t             cur;
    qct_set_t              cur_set;
    qct_set_t              lnk_src;
    logic                  lnk_null;
    logic [2:0]            lnk_w;
    logic [2:0]            lnk_n;
    logic [63:0]           chain_event_flags;
    logic [63:0]           interrupt_pending_flags;
    logic [31:0]           rdata;
    qct_tr_t               tr;
  } qct_state_t;

endpackage

// File: hdl/qct_trigger_ctrl.sv
/*
  Quick channel trigger, queue, submission and completion logic with its
  setting memory and register port.
  Assumes a synchronous master on the register port and a transfer controller
  that takes requests with ready and returns completion codes as pulses.
*/
// Implementation choices: the register offsets and strobed register access.
`timescale 1ns/10ps
`include "qct_params.svh"

module qct_trigger_ctrl
  import qct_pkg::*;
(
  input  wire logic        i_ref_clk,
  input  wire logic        i_sys_rst,
  input  wire logic [15:0] i_addr,
  input  wire logic [31:0] i_wr_data,
  input  wire logic        i_wr_stb,
  input  wire logic        i_rd_stb,
  input  wire logic        i_tr_ready,
  input  wire qct_done_t   i_done,
  output qct_tr_t          o_tr,
  output logic [31:0]      o_rd_data,
  output logic [63:0]      o_chain_flags,
  output logic [63:0]      o_irq_flags,
  output logic [7:0]       o_event_flags
);

  qct_state_t  q;
  qct_state_t  d;

  // setting memory: 128 sets of eight words
  logic [31:0] mem [0:1023];

  // one memory write port, shared by software, write-back and link copy
  logic        m_we;
  logic [9:0]  m_idx;
  logic [31:0] m_dat;
  logic        m_trig_ok;
  logic        sw_mem;

  // per-channel strobes for this cycle
  logic [7:0]  trig;
  logic [7:0]  clr;
  logic [7:0]  miss_set;
  logic [7:0]  miss_clr;

  // completion bits raised and cleared this cycle
  logic [63:0] cer_set;
  logic [63:0] cer_clr;
  logic [63:0] ipr_set;
  logic [63:0] ipr_clr;

  // words of the set under evaluation
  logic [31:0] w0;
  logic [31:0] w1;
  logic [31:0] w2;
  logic [31:0] w3;
  logic [31:0] w4;
  logic [31:0] w5;

  // decodes of the current set
  logic        is_null;
  logic        is_dummy;
  logic        is_final;
  logic        rc;
  logic        ri;

  // queue movement
  logic        deq;
  logic        enq;
  qct_chan_t   enq_ch;

  // one bit of the 64 chain or pending flags per code
  // shared by returned and internally raised codes
  function automatic logic [63:0] code_bit(input logic [5:0] code, input logic on);
    code_bit = on ? (64'h1 << code) : 64'h0;
  endfunction

  // words of the null set used when linking to the null link
  function automatic logic [31:0] null_word(input logic [2:0] w);
    null_word = (w == 3'h2) ? {16'h0000, `QCT_NULL_LINK} : 32'h0000_0000;
  endfunction

  // counts after one request; A-sync walks second count, reloading it per row
  function automatic logic [31:0] next_counts(input logic [31:0] c, input logic [31:0] r,
                                              input logic ab);
    if (ab) begin
      // AB-sync uses one third-dim step per request
      next_counts = {c[31:16] - 16'h0001, c[15:0]};
    end else if (c[15:0] > 16'h0001) begin
      next_counts = {c[31:16], c[15:0] - 16'h0001};
    end else begin
      next_counts = {c[31:16] - 16'h0001, r[31:16]};
    end
  endfunction

  // words of the set under evaluation: ctrl, {third,second}, {reload,link}, first
  assign w0 = mem[{q.cur_set, 3'h0}];
  assign w1 = mem[{q.cur_set, 3'h1}];
  assign w2 = mem[{q.cur_set, 3'h2}];
  assign w3 = mem[{q.cur_set, 3'h3}];
  assign w4 = mem[{q.cur_set, 3'h4}];
  assign w5 = mem[{q.cur_set, 3'h5}];

  // null: no counts at all; dummy: any count zero
  // a null set is also dummy; only null flags an error
  assign is_null  = (w1 == 32'h0000_0000) && (w3[15:0] == 16'h0000);
  assign is_dummy = (w1[15:0] == 16'h0000) || (w1[31:16] == 16'h0000) ||
                    (w3[15:0] == 16'h0000);
  // last request of the set, A-sync and AB-sync
  assign is_final = w0[`QCT_F_AB] ? (w1[31:16] == 16'h0001) :
                    ((w1[15:0] == 16'h0001) && (w1[31:16] == 16'h0001));
  // final enables only on the last request, midway enables on the rest
  assign rc = is_final ? w0[`QCT_F_FCH]  : w0[`QCT_F_MCH];
  assign ri = is_final ? w0[`QCT_F_FIRQ] : w0[`QCT_F_MIRQ];

  // any write below the register area goes to the setting memory
  assign sw_mem = i_wr_stb && (i_addr < `QCT_MEM_TOP);

  always_comb begin
    d         = q;
    m_we      = 1'b0;
    m_idx     = i_addr[11:2];
    m_dat     = i_wr_data;
    m_trig_ok = 1'b1;
    clr       = 8'h00;
    miss_set  = 8'h00;
    miss_clr  = 8'h00;
    cer_set   = 64'h0;
    cer_clr   = 64'h0;
    ipr_set   = 64'h0;
    ipr_clr   = 64'h0;
    trig      = 8'h00;
    deq       = 1'b0;
    enq       = 1'b0;
    enq_ch    = 3'h0;
    d.rdata   = 32'h0000_0000;

    // software has the memory port; the engine waits a cycle when they collide
    if (sw_mem) begin
      m_we = 1'b1;
    end

    // register writes; clears are write-one-to-clear
    if (i_wr_stb && !sw_mem) begin
      // addresses outside the map fall to default and are ignored
      case (i_addr)
        `QCT_REG_MISS:   miss_clr = i_wr_data[7:0];
        `QCT_REG_EN:     d.en = i_wr_data[7:0];
        `QCT_REG_CER_LO: cer_clr[31:0] = i_wr_data;
        `QCT_REG_CER_HI: cer_clr[63:32] = i_wr_data;
        `QCT_REG_IPR_LO: ipr_clr[31:0] = i_wr_data;
        `QCT_REG_IPR_HI: ipr_clr[63:32] = i_wr_data;
        default: begin
          if (i_addr[15:4] == `QCT_REG_RAE >> 4) begin
            d.rae[i_addr[3:2]] = i_wr_data[7:0];
          end
          if (i_addr[15:5] == `QCT_REG_MAP >> 5) begin
            d.map[i_addr[4:2]] = {i_wr_data[`QCT_MAP_SET +: 7], i_wr_data[`QCT_MAP_WORD +: 3]};
          end
        end
      endcase
    end

    // register reads, answered in the next cycle; unmapped reads give zero
    if (i_rd_stb) begin
      if (i_addr < `QCT_MEM_TOP) begin
        d.rdata = mem[i_addr[11:2]];
      end else begin
        // register side; at most one read per cycle
        case (i_addr)
          `QCT_REG_FLAGS:  d.rdata = {24'h0, q.flags};
          `QCT_REG_MISS:   d.rdata = {24'h0, q.miss};
          `QCT_REG_EN:     d.rdata = {24'h0, q.en};
          `QCT_REG_CER_LO: d.rdata = q.chain_event_flags[31:0];
          `QCT_REG_CER_HI: d.rdata = q.chain_event_flags[63:32];
          `QCT_REG_IPR_LO: d.rdata = q.interrupt_pending_flags[31:0];
          `QCT_REG_IPR_HI: d.rdata = q.interrupt_pending_flags[63:32];
          default: begin
            if (i_addr[15:4] == `QCT_REG_RAE >> 4) begin
              d.rdata = {24'h0, q.rae[i_addr[3:2]]};
            end
            if (i_addr[15:5] == `QCT_REG_MAP >> 5) begin
              d.rdata = {20'h0, q.map[i_addr[4:2]].set, q.map[i_addr[4:2]].word, 2'b00};
            end
          end
        endcase
      end
    end

    // channel engine
    case (q.st)
      ST_IDLE: begin
        // the queue head is taken for evaluation
        // one channel is served at a time, in queue order
        if (q.cnt != 4'h0) begin
          deq       = 1'b1;
          d.cur     = q.queue[q.head];
          d.cur_set = q.map[q.queue[q.head]].set;
          d.head    = q.head + 3'h1;
          d.st      = ST_EVAL;
        end
      end

      // a set with a zero count is never submitted
      ST_EVAL: begin
        if (is_dummy) begin
          // nothing submitted; enabled codes still raised internally
          clr[q.cur] = 1'b1;
          cer_set    = code_bit(w0[`QCT_F_CODE +: 6], w0[`QCT_F_FCH]);
          ipr_set    = code_bit(w0[`QCT_F_CODE +: 6], w0[`QCT_F_FIRQ]);
          if (is_null) begin
            miss_set[q.cur] = 1'b1;
            d.st            = ST_IDLE;
          end else if (w0[`QCT_F_HOLD]) begin
            d.st = ST_IDLE;
          end else begin
            d.lnk_src  = w2[11:5];
            d.lnk_null = (w2[15:0] == `QCT_NULL_LINK);
            d.lnk_w    = q.map[q.cur].word + 3'h1;
            d.lnk_n    = 3'h0;
            d.st       = ST_LINK;
          end
        end else begin
          // request carries first bytes (A) or first times second bytes (AB)
          d.tr.valid     = 1'b1;
          d.tr.chan      = q.cur;
          d.tr.set       = q.cur_set;
          d.tr.bytes     = w0[`QCT_F_AB] ? ({16'h0, w3[15:0]} * {16'h0, w1[15:0]})
                                         : {16'h0, w3[15:0]};
          d.tr.src       = w4;
          d.tr.dst       = w5;
          d.tr.code      = w0[`QCT_F_CODE +: 6];
          // early finish keeps the code at home instead of asking for it
          d.tr.ret_chain = rc && !w0[`QCT_F_EARLY];
          d.tr.ret_irq   = ri && !w0[`QCT_F_EARLY];
          d.tr.final_tr  = is_final;
          d.st           = ST_SUBMIT;
        end
      end

      // request holds until taken; the flag stays set meanwhile
      ST_SUBMIT: begin
        if (i_tr_ready) begin
          d.tr.valid = 1'b0;
          clr[q.cur] = 1'b1;
          // early finish: complete at submission, code generated here
          if (w0[`QCT_F_EARLY]) begin
            cer_set = code_bit(w0[`QCT_F_CODE +: 6], rc);
            ipr_set = code_bit(w0[`QCT_F_CODE +: 6], ri);
          end
          d.st = ST_WB;
        end
      end

      // counts are written back after every request
      ST_WB: begin
        // count write-back; the last request also starts the link update
        // a colliding software write costs a cycle, never an update
        if (!sw_mem) begin
          m_we  = 1'b1;
          m_idx = {q.cur_set, 3'h1};
          m_dat = next_counts(w1, w2, w0[`QCT_F_AB]);
          if (is_final && !w0[`QCT_F_HOLD]) begin
            d.lnk_src  = w2[11:5];
            d.lnk_null = (w2[15:0] == `QCT_NULL_LINK);
            d.lnk_w    = q.map[q.cur].word + 3'h1;
            d.lnk_n    = 3'h0;
            d.st       = ST_LINK;
          end else begin
            d.st = ST_IDLE;
          end
        end
      end

      // link copy, eight cycles without collisions
      ST_LINK: begin
        // copy eight words ending on the trigger word, so the new set is whole
        // before it retriggers itself
        // the null link writes zeros, with the null link in word 2, and leaves the channel quiet
        if (!sw_mem) begin
          m_we      = 1'b1;
          m_idx     = {q.cur_set, q.lnk_w};
          m_dat     = q.lnk_null ? null_word(q.lnk_w) : mem[{q.lnk_src, q.lnk_w}];
          m_trig_ok = !q.lnk_null;
          d.lnk_w   = q.lnk_w + 3'h1;
          d.lnk_n   = q.lnk_n + 3'h1;
          if (q.lnk_n == 3'h7) begin
            d.st = ST_IDLE;
          end
        end
      end

      // unreachable codes fall back to idle
      default: d.st = ST_IDLE;
    endcase

    // trigger-word hits from software or from a link copy
    // a disabled channel ignores its trigger word entirely
    for (int c = 0; c < 8; c++) begin
      if (m_we && m_trig_ok && q.en[c] && (m_idx == {q.map[c].set, q.map[c].word})) begin
        trig[c] = 1'b1;
      end
      // a trigger on a still-pending flag is a miss; one landing on the clear wins
      if (trig[c] && q.flags[c] && !clr[c]) begin
        miss_set[c] = 1'b1;
      end
    end

    d.flags = (q.flags & ~clr) | trig;
    d.miss  = (q.miss & ~miss_clr) | miss_set;

    // lowest pending channel enters the queue first; one entry per channel
    for (int c = 7; c >= 0; c--) begin
      if (q.flags[c] && !q.queued[c]) begin
        enq    = 1'b1;
        enq_ch = 3'(c);
      end
    end

    d.queued = q.queued & ~clr;
    if (enq) begin
      d.queue[q.tail]  = enq_ch;
      d.tail           = q.tail + 3'h1;
      d.queued[enq_ch] = 1'b1;
    end
    // depth eight never overflows: each channel holds one entry at most
    d.cnt = q.cnt + {3'h0, enq} - {3'h0, deq};

    // codes returned by the transfer controller name the finished transfer
    if (i_done.valid) begin
      cer_set = cer_set | code_bit(i_done.code, i_done.chain);
      ipr_set = ipr_set | code_bit(i_done.code, i_done.irq);
    end

    // hardware set wins over a software clear in the same cycle
    d.chain_event_flags = (q.chain_event_flags & ~cer_clr) | cer_set;
    d.interrupt_pending_flags = (q.interrupt_pending_flags & ~ipr_clr) | ipr_set;
  end

  // state register; all-zero reset maps every channel to set 0, word 0
  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  // setting memory has no reset; software must load a set before use
  always_ff @(posedge i_ref_clk) begin
    if (m_we) begin
      mem[m_idx] <= m_dat;
    end
  end

  // outputs come straight from the state register
  assign o_tr          = q.tr;
  assign o_rd_data     = q.rdata;
  assign o_chain_flags = q.chain_event_flags;
  assign o_irq_flags   = q.interrupt_pending_flags;
  assign o_event_flags = q.flags;

endmodule

// File: bench/qct_tc_model.sv
/*
  transfer controller stand-in: accepts requests, returns completion codes.
  assumes the block's request and completion structs from qct_pkg.
*/
`timescale 1ns/10ps
module qct_tc_model
  import qct_pkg::*;
(
  input  wire logic    i_ref_clk,
  input  wire logic    i_sys_rst,
  input  wire qct_tr_t i_tr,
  input  wire logic    i_stall,
  input  wire logic    i_slow,
  output logic         o_ready,
  output qct_done_t    o_done
);
  logic [1:0] dly_q;
  logic [2:0] ret_q;
  qct_tr_t    got_q;

  // accept after 0 or 2 idle cycles; code returns 3 cycles after acceptance
  always_ff @(posedge i_ref_clk) begin
    o_ready      <= 1'b0;
    o_done.valid <= 1'b0;
    if (i_sys_rst) begin
      dly_q  <= 2'h0;
      ret_q  <= 3'h0;
      o_done <= '0;
    end else begin
      o_done.code <= ~o_done.code; // idle code churns so a stale value never matches
      if (i_tr.valid && !o_ready && !i_stall) begin
        dly_q <= dly_q + 2'h1;
        if (!i_slow || dly_q == 2'h2) begin
          o_ready <= 1'b1;
          dly_q   <= 2'h0;
        end
      end
      if (o_ready && i_tr.valid) begin
        got_q <= i_tr;
        ret_q <= 3'h3;
      end else if (ret_q != 3'h0) begin
        ret_q <= ret_q - 3'h1;
        // codes only after the transfer is done, per request
        if (ret_q == 3'h1 && (got_q.ret_chain || got_q.ret_irq)) begin
          o_done <= '{1'b1, got_q.code, got_q.ret_chain, got_q.ret_irq};
        end
      end
    end
  end
endmodule

// File: bench/qct_trigger_monitor.sv
/*
  port assertions for the quick channel block.
  assumes one clock and a synchronous active-high reset.
*/
`timescale 1ns/10ps
module qct_trigger_monitor
  import qct_pkg::*;
(
  input wire logic        i_ref_clk,
  input wire logic        i_sys_rst,
  input wire logic        i_wr_stb,
  input wire logic        i_rd_stb,
  input wire logic        i_tr_ready,
  input wire qct_done_t   i_done,
  input wire qct_tr_t     o_tr,
  input wire logic [31:0] o_rd_data,
  input wire logic [63:0] o_chain_flags,
  input wire logic [63:0] o_irq_flags,
  input wire logic [7:0]  o_event_flags
);
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (i_sys_rst);

  // request handed over, or still waiting
  sequence s_accept;
    o_tr.valid && i_tr_ready;
  endsequence
  sequence s_wait;
    o_tr.valid && !i_tr_ready;
  endsequence

  a_tr_holds: assert property (s_wait |=> o_tr.valid && $stable(o_tr))
    else $error("request changed before acceptance");
  a_accept_gap: assert property (s_accept |=> !o_tr.valid [*2])
    else $error("request valid right after acceptance");
  a_tr_flagged: assert property (o_tr.valid |-> o_event_flags[o_tr.chan])
    else $error("request without its event flag");
  a_flag_served: assert property ($rose(o_event_flags[0]) |-> ##[1:40]
    (o_tr.valid || !o_event_flags[0]))
    else $error("event flag never served");
  a_done_irq: assert property (i_done.valid && i_done.irq |=>
    o_irq_flags[$past(i_done.code)])
    else $error("returned code did not set pending bit");
  a_done_chain: assert property (i_done.valid && i_done.chain |=>
    o_chain_flags[$past(i_done.code)])
    else $error("returned code did not set chain bit");
  a_rd_idle_zero: assert property (!i_rd_stb |=> o_rd_data == 32'h0)
    else $error("read data outside read slot");
  a_flags_sticky: assert property (!i_wr_stb |=>
    ((o_irq_flags & $past(o_irq_flags)) == $past(o_irq_flags)) &&
    ((o_chain_flags & $past(o_chain_flags)) == $past(o_chain_flags)))
    else $error("completion flag lost without a clear");
endmodule

bind qct_trigger_ctrl qct_trigger_monitor u_mon (.i_ref_clk, .i_sys_rst, .i_wr_stb,
  .i_rd_stb, .i_tr_ready, .i_done, .o_tr, .o_rd_data, .o_chain_flags, .o_irq_flags,
  .o_event_flags);

// File: bench/tb_top.sv
/*
  self-checking bench for the quick channel block.
  assumes package, constants header and the transfer controller stand-in.
*/
`timescale 1ns/10ps
`include "qct_params.svh"
module tb_top
  import qct_pkg::*;
;
  typedef struct packed {
    logic [31:0] ctl, cnt, first, bytes;
    logic        fin, ch, irq;
  } qct_row_t;

  logic        i_ref_clk = 1'b0;
  logic        i_sys_rst = 1'b1;
  logic [15:0] i_addr = 16'h0000;
  logic [31:0] i_wr_data = 32'h0;
  logic        i_wr_stb = 1'b0;
  logic        i_rd_stb = 1'b0;
  logic        stall = 1'b0;
  logic        slow = 1'b0;
  logic        i_tr_ready;
  qct_done_t   i_done;
  qct_tr_t     o_tr;
  logic [31:0] o_rd_data, d;
  logic [63:0] o_chain_flags, o_irq_flags;
  logic [7:0]  o_event_flags;
  logic [5:0]  code;
  logic        seen;
  qct_row_t    rows [6];
  int          mismatches = 0;
  int          total_checks = 0;

  always #5 i_ref_clk = ~i_ref_clk;

  qct_trigger_ctrl u_dut (.i_ref_clk, .i_sys_rst, .i_addr, .i_wr_data, .i_wr_stb,
    .i_rd_stb, .i_tr_ready, .i_done, .o_tr, .o_rd_data, .o_chain_flags,
    .o_irq_flags, .o_event_flags);
  qct_tc_model u_tc (.i_ref_clk, .i_sys_rst, .i_tr(o_tr), .i_stall(stall),
    .i_slow(slow), .o_ready(i_tr_ready), .o_done(i_done));

  function automatic logic [31:0] mk(logic ab, e, logic [5:0] c, logic fi, mi, fc, mc);
    return {8'h00, mc, fc, mi, fi, 2'h0, c, e, 7'h00, 1'h1, 2'h0, ab};
  endfunction

  task automatic end_sim();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [63:0] seen_v, exp);
    total_checks++;
    if (seen_v !== exp) begin
      mismatches++;
      $display("MISMATCH %s expected %0h seen %0h", nm, exp, seen_v);
    end
  endtask

  // write strobe stays up for back-to-back writes; idle lowers it
  task automatic wr(input logic [15:0] a, input logic [31:0] v);
    i_addr <= a;
    i_wr_data <= v;
    i_wr_stb <= 1'b1;
    @(posedge i_ref_clk);
  endtask

  task automatic idle();
    i_wr_stb <= 1'b0;
    @(posedge i_ref_clk);
  endtask

  task automatic rd(input logic [15:0] a, output logic [31:0] v);
    i_wr_stb <= 1'b0;
    i_addr <= a;
    i_rd_stb <= 1'b1;
    @(posedge i_ref_clk);
    i_rd_stb <= 1'b0;
    #1 v = o_rd_data;
    @(posedge i_ref_clk);
  endtask

  task automatic prog(input logic [6:0] s, input logic [31:0] c, n, l, f);
    wr({4'h0, s, 5'h00}, c);
    wr({4'h0, s, 5'h04}, n);
    wr({4'h0, s, 5'h08}, l);
    wr({4'h0, s, 5'h0C}, f);
    wr({4'h0, s, 5'h10}, 32'h0);
    wr({4'h0, s, 5'h14}, 32'h0);
  endtask

  // trigger word is word 7 of the set in every mapping used here
  // the trigger write alone starts a quick transfer, no event set write
  task automatic trig(input logic [6:0] s);
    wr({4'h0, s, 5'h1C}, 32'h0);
    idle();
  endtask

  task automatic wait_v(input logic lvl);
    int n = 0;
    while (o_tr.valid !== lvl) begin
      @(posedge i_ref_clk);
      #1 n++;
      if (n > 60) begin
        mismatches++;
        end_sim();
      end
    end
  endtask

  // bounded wait for completion bits; runs full length when none are due
  task automatic wait_done();
    for (int n = 0; n < 20 && (o_chain_flags | o_irq_flags) == 64'h0; n++) begin
      @(posedge i_ref_clk);
      #1;
    end
  endtask

  task automatic clear();
    wr(`QCT_REG_CER_LO, 32'hFFFFFFFF);
    wr(`QCT_REG_CER_HI, 32'hFFFFFFFF);
    wr(`QCT_REG_IPR_LO, 32'hFFFFFFFF);
    wr(`QCT_REG_IPR_HI, 32'hFFFFFFFF);
    wr(`QCT_REG_MISS, 32'hFFFFFFFF);
    idle();
    chk("cleared", o_chain_flags | o_irq_flags, 64'h0);
  endtask

  initial begin
    // rows 0, 1 and 4 finish in one event; rows 2, 3 and 5 are deliberate intermediates
    rows[0] = '{mk(0, 0, 6'h05, 1, 0, 0, 0), 32'h00010001, 32'h10, 32'h10, 1, 0, 1};
    rows[1] = '{mk(1, 1, 6'h09, 0, 0, 1, 0), 32'h00010004, 32'h08, 32'h20, 1, 1, 0};
    rows[2] = '{mk(0, 0, 6'h03, 0, 1, 0, 0), 32'h00010002, 32'h04, 32'h04, 0, 0, 1};
    rows[3] = '{mk(0, 1, 6'h28, 1, 0, 1, 0), 32'h00010002, 32'h04, 32'h04, 0, 0, 0};
    rows[4] = '{mk(1, 0, 6'h21, 1, 1, 1, 1), 32'h00010003, 32'h05, 32'h0F, 1, 1, 1};
    rows[5] = '{mk(1, 0, 6'h0C, 1, 0, 0, 1), 32'h00020003, 32'h02, 32'h06, 0, 1, 0};
    repeat (2) @(posedge i_ref_clk);
    i_sys_rst <= 1'b0;
    @(posedge i_ref_clk);
    rd(`QCT_REG_MAP, d);
    chk("map reset", d, 64'h0);
    rd(16'h1100, d);
    chk("unmapped", d, 64'h0);
    wr(`QCT_REG_EN, 32'h1);
    wr(`QCT_REG_MAP, 32'h3C);
    for (int i = 0; i < 6; i++) begin
      slow <= i[0];
      code = rows[i].ctl[17:12];
      prog(7'h01, rows[i].ctl, rows[i].cnt, 32'h0000FFFF, rows[i].first);
      trig(7'h01);
      wait_v(1'b1);
      chk("chan", o_tr.chan, 64'h0);
      chk("bytes", o_tr.bytes, rows[i].bytes);
      chk("final", o_tr.final_tr, rows[i].fin);
      chk("code", o_tr.code, code);
      wait_done();
      chk("chain", o_chain_flags, rows[i].ch ? 64'h1 << code : 64'h0);
      chk("irq", o_irq_flags, rows[i].irq ? 64'h1 << code : 64'h0);
      chk("flag idle", o_event_flags, 64'h0);
      clear();
    end
    // second trigger while the first still waits for the controller
    stall <= 1'b1;
    prog(7'h01, rows[0].ctl, rows[0].cnt, 32'h0000FFFF, rows[0].first);
    trig(7'h01);
    wait_v(1'b1);
    trig(7'h01);
    rd(`QCT_REG_MISS, d);
    chk("miss", d, 64'h1);
    stall <= 1'b0;
    wait_done();
    clear();
    // disabled channel ignores its trigger word, then works once enabled
    wr(`QCT_REG_MAP + 16'h0004, 32'h7C);
    prog(7'h03, rows[0].ctl, rows[0].cnt, 32'h0000FFFF, rows[0].first);
    trig(7'h03);
    repeat (2) @(posedge i_ref_clk);
    chk("disabled", o_event_flags, 64'h0);
    wr(`QCT_REG_EN, 32'h3);
    trig(7'h03);
    wait_v(1'b1);
    chk("chan1", o_tr.chan, 64'h1);
    wait_done();
    clear();
    // null set: nothing submitted, final code raised internally, error flagged
    prog(7'h01, mk(0, 0, 6'h07, 1, 0, 0, 0), 32'h0, 32'h0000FFFF, 32'h0);
    trig(7'h01);
    seen = 1'b0;
    repeat (12) begin
      @(posedge i_ref_clk);
      #1 seen = seen | (o_tr.valid !== 1'b0);
    end
    chk("null req", seen, 64'h0);
    chk("null irq", o_irq_flags, 64'h80);
    rd(`QCT_REG_MISS, d);
    chk("null err", d, 64'h1);
    clear();
    // link copy of set 2 into the mapped set retriggers the channel
    prog(7'h02, rows[0].ctl, rows[0].cnt, 32'h0000FFFF, 32'h18);
    prog(7'h01, rows[0].ctl & ~32'h8, rows[0].cnt, 32'h40, 32'h10);
    trig(7'h01);
    wait_v(1'b1);
    chk("first", o_tr.bytes, 64'h10);
    wait_v(1'b0);
    wait_v(1'b1);
    chk("linked", o_tr.bytes, 64'h18);
    chk("linked set", o_tr.set, 64'h1);
    // let the second code return before clearing, so the clear check is clean
    wait_v(1'b0);
    repeat (8) @(posedge i_ref_clk);
    chk("link irq", o_irq_flags, 64'h20);
    clear();
    end_sim();
  end
endmodule
